// ---- rx_input_consts.svh ----
`ifndef RX_INPUT_CONSTS_SVH
`define RX_INPUT_CONSTS_SVH

// byte addresses of the control and status words
`define ADDR_CTRL 8'h00
`define ADDR_STAT 8'h04
`define ADDR_DATA 8'h08
`define ADDR_BITS 8
// control field positions
`define CTRL_SINGLE 0
`define CTRL_RZ 1
`define CTRL_FALL 2
`define CTRL_ANALOG 3
`define CTRL_RAW 4
`define CTRL_W 5
// status field positions
`define STAT_VALID 0
`define STAT_CV 1
`define STAT_POS 2
`define STAT_NEG 3
// reset value of control
`define CTRL_RST 5'h00
// axi response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// recovered clock: half period in system cycles when no edge source
`define HALF_GAP 4'h8

`endif

// ---- rx_input_pkg.sv ----
`default_nettype none
package rx_input_pkg;
  // source of recovered timing
  typedef enum logic [1:0] {src_ext, src_rz, src_analog} clk_src_t;
  // one received bit with its violation flag
  typedef struct packed {
    logic data;
    logic cv;
  } rx_bit_t;
endpackage
`default_nettype wire

// ---- bit_buf_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// valid/ready carrier for received bits
interface bit_buf_if;
  import rx_input_pkg::*;
  logic valid;
  logic ready;
  rx_bit_t item;
  modport src (output valid, output item, input ready);
  modport dst (input valid, input item, output ready);
endinterface
`default_nettype wire

// ---- bit_buf.sv ----
`timescale 1ns/1ps
`default_nettype none
// two-entry buffer, no bubble, full back-pressure
module bit_buf
  import rx_input_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  bit_buf_if.dst in_p,
  bit_buf_if.src out_p
);
  rx_bit_t mem_q [2]; // storage
  logic rd_q; // read pointer
  logic wr_q; // write pointer
  logic [1:0] cnt_q; // occupancy
  wire push = in_p.valid && in_p.ready;
  wire pop = out_p.valid && out_p.ready;
  assign in_p.ready = (cnt_q != 2'h2);
  assign out_p.valid = (cnt_q != 2'h0);
  assign out_p.item = mem_q[rd_q];
  // storage write
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[wr_q] <= in_p.item;
    end
  end
  // pointers and count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      rd_q <= rd_q ^ pop;
      wr_q <= wr_q ^ push;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// ---- rx_input.sv ----
// Overview of operation
// - dual rail input, RZ or NRZ selectable
// - NRZ rails sampled on chosen line edge
// - RZ mode clock derived from rail pulses
// - single rail data and violation on edge
// - analog mode turns rail pins into outputs
// - positive excursion gives positive rail pulse
// - negative excursion gives negative rail pulse
// - recovered clock from analog, RZ or line
// - data output changes on recovered clock fall
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "rx_input_consts.svh"
module rx_input
  import rx_input_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // line pins; rail pins double as sliced outputs
  input wire logic rx_pos_rail_in,
  input wire logic rx_neg_rail_in,
  output logic sliced_pos_pulse_out,
  output logic sliced_neg_pulse_out,
  output logic sliced_pos_oe,
  output logic sliced_neg_oe,
  input wire logic ext_line_clk_in,
  // comparator results of the analog slicer
  input wire logic analog_pos_in,
  input wire logic analog_neg_in,
  // recovered clock and serial data
  output logic recovered_clk_out,
  output logic decoded_rx_data_out,
  output logic raw_rx_data_out,
  // downstream bit stream
  output logic bit_valid,
  input wire logic bit_ready,
  output logic bit_data,
  output logic bit_cv
);
  // two-flop synchronisers for every pin
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] prev_q; // previous synchronised value for edge find
  always_ff @(posedge aclk) begin
    sync1_q <= {analog_neg_in, analog_pos_in, ext_line_clk_in, rx_neg_rail_in, rx_pos_rail_in};
    sync2_q <= sync1_q;
    prev_q <= sync2_q;
  end
  wire pos_s = sync2_q[0];
  wire neg_s = sync2_q[1];
  wire lclk_s = sync2_q[2];
  wire apos_s = sync2_q[3];
  wire aneg_s = sync2_q[4];
  // control register
  logic [`CTRL_W-1:0] ctrl_q;
  wire single_mode = ctrl_q[`CTRL_SINGLE];
  wire rz_mode = ctrl_q[`CTRL_RZ] && !single_mode;
  wire fall_edge = ctrl_q[`CTRL_FALL];
  wire analog_on = ctrl_q[`CTRL_ANALOG];
  wire raw_sel = ctrl_q[`CTRL_RAW];
  clk_src_t src;
  assign src = analog_on ? src_analog : (rz_mode ? src_rz : src_ext);
  // line clock edge detection
  wire lclk_rise = lclk_s && !prev_q[2];
  wire lclk_fall = !lclk_s && prev_q[2];
  wire ext_strobe = fall_edge ? lclk_fall : lclk_rise;
  // rail pulse rises in RZ and analog modes
  wire p_pulse = analog_on ? (apos_s && !prev_q[3]) : (pos_s && !prev_q[0]);
  wire n_pulse = analog_on ? (aneg_s && !prev_q[4]) : (neg_s && !prev_q[1]);
  wire gap_done;
  // RZ: any pulse marks a one; gaps of a bit period mark zeros
  wire rz_strobe = p_pulse || n_pulse || gap_done;
  wire bit_strobe = (src == src_ext) ? ext_strobe : rz_strobe;
  // bit value and violation
  logic last_pol_q; // polarity of last mark
  wire rz_one = p_pulse || n_pulse;
  wire rz_cv = (p_pulse && last_pol_q) || (n_pulse && !last_pol_q); // same polarity twice
  wire ext_data = single_mode ? pos_s : (pos_s ^ neg_s);
  wire ext_cv = single_mode ? neg_s : (pos_s && neg_s);
  logic [3:0] gap_q; // cycles since last strobe
  // a whole bit period without a pulse counts as a zero
  assign gap_done = (gap_q == 4'(2 * `HALF_GAP - 1)) && (src != src_ext);
  // gap counter and mark polarity
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_q <= 4'h0;
      last_pol_q <= 1'b0;
    end else begin
      gap_q <= bit_strobe ? 4'h0 : gap_q + 4'h1;
      if (p_pulse) begin
        last_pol_q <= 1'b1;
      end else if (n_pulse) begin
        last_pol_q <= 1'b0;
      end
    end
  end
  // push the sampled bit through the buffer into the local domain
  bit_buf_if in_b ();
  bit_buf_if out_b ();
  assign in_b.valid = bit_strobe;
  assign in_b.item.data = (src == src_ext) ? ext_data : rz_one;
  assign in_b.item.cv = (src == src_ext) ? ext_cv : rz_cv;
  bit_buf u_buf (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_p(in_b),
    .out_p(out_b)
  );
  assign bit_valid = out_b.valid;
  assign out_b.ready = bit_ready;
  assign bit_data = out_b.item.data;
  assign bit_cv = out_b.item.cv;
  // recovered clock: high after strobe; low on the other line edge in line clock mode,
  // otherwise half a bit period later
  logic rclk_q;
  logic dec_q;
  logic raw_q;
  logic held_q; // bit captured at strobe for output on fall
  wire ext_half = fall_edge ? lclk_rise : lclk_fall; // opposite line edge
  wire half_due = (src == src_ext) ? ext_half : (gap_q == `HALF_GAP - 4'h1);
  // a strobe keeps the clock high, so no fall and no data change then
  wire rclk_fall = rclk_q && half_due && !bit_strobe;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rclk_q <= 1'b0;
      held_q <= 1'b0;
      dec_q <= 1'b0;
      raw_q <= 1'b0;
    end else begin
      if (bit_strobe) begin
        rclk_q <= 1'b1;
        held_q <= in_b.item.data;
      end else if (rclk_fall) begin
        rclk_q <= 1'b0;
      end
      if (rclk_fall) begin
        dec_q <= held_q && !raw_sel;
        raw_q <= held_q;
      end
    end
  end
  assign recovered_clk_out = rclk_q;
  assign decoded_rx_data_out = dec_q;
  assign raw_rx_data_out = raw_q;
  // sliced outputs drive rail pins when analog is on
  logic spos_q;
  logic sneg_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spos_q <= 1'b0;
      sneg_q <= 1'b0;
    end else begin
      spos_q <= analog_on && apos_s;
      sneg_q <= analog_on && aneg_s;
    end
  end
  assign sliced_pos_pulse_out = spos_q;
  assign sliced_neg_pulse_out = sneg_q;
  assign sliced_pos_oe = analog_on;
  assign sliced_neg_oe = analog_on;
  // axi4-lite write path
  logic aw_q;
  logic w_q;
  logic [`ADDR_BITS-1:0] awa_q;
  logic [31:0] wd_q;
  logic bv_q;
  logic [1:0] br_q;
  wire do_wr = aw_q && w_q && !bv_q;
  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready = !w_q && !bv_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= '0;
      wd_q <= '0;
      bv_q <= 1'b0;
      br_q <= `RESP_OKAY;
      ctrl_q <= `CTRL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr[`ADDR_BITS-1:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
      end
      if (do_wr) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bv_q <= 1'b1;
        br_q <= (awa_q == `ADDR_CTRL) ? `RESP_OKAY : `RESP_SLVERR;
        if (awa_q == `ADDR_CTRL && s_axi_wstrb[0]) begin
          ctrl_q <= wd_q[`CTRL_W-1:0];
        end
      end else if (bv_q && s_axi_bready) begin
        bv_q <= 1'b0;
      end
    end
  end
  // axi4-lite read path
  wire [7:0] ra = s_axi_araddr[`ADDR_BITS-1:0];
  wire [31:0] stat_w = {28'h0, neg_s, pos_s, out_b.item.cv, out_b.valid};
  wire ra_ok = (ra == `ADDR_CTRL) || (ra == `ADDR_STAT);
  logic rv_q;
  logic [31:0] rd_q;
  logic [1:0] rr_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rv_q <= 1'b0;
      rd_q <= 32'h0;
      rr_q <= `RESP_OKAY;
    end else if (s_axi_arvalid && !rv_q) begin
      rv_q <= 1'b1;
      rd_q <= (ra == `ADDR_CTRL) ? {27'h0, ctrl_q} : ((ra == `ADDR_STAT) ? stat_w : 32'h0);
      rr_q <= ra_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rv_q && s_axi_rready) begin
      rv_q <= 1'b0;
    end
  end
  // checks
  chk_oe_follows_analog: assert property (@(posedge aclk) disable iff (!aresetn)
    sliced_pos_oe == ctrl_q[`CTRL_ANALOG]) else $error("rail drive not tied to analog mode");
  // sliced outputs stay quiet while the rail pins are inputs
  chk_quiet_when_input: assert property (@(posedge aclk) disable iff (!aresetn)
    (!analog_on && !$past(analog_on)) |-> !(sliced_pos_pulse_out || sliced_neg_pulse_out))
    else $error("sliced output active while rails are inputs");
  chk_slice_pos: assert property (@(posedge aclk) disable iff (!aresetn)
    (analog_on && apos_s) |=> sliced_pos_pulse_out) else $error("positive slice missed");
  chk_slice_neg: assert property (@(posedge aclk) disable iff (!aresetn)
    (analog_on && aneg_s) |=> sliced_neg_pulse_out) else $error("negative slice missed");
  chk_ext_sample: assert property (@(posedge aclk) disable iff (!aresetn)
    (src == src_ext && ext_strobe) |-> in_b.valid) else $error("line edge not sampled");
  chk_ext_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    (src == src_ext && in_b.valid) |-> (fall_edge ? lclk_fall : lclk_rise)) else $error("wrong edge");
  chk_rz_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    (src == src_rz && (p_pulse || n_pulse)) |-> (in_b.valid && in_b.item.data)) else $error("rz mark lost");
  chk_rclk_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    bit_strobe |=> recovered_clk_out) else $error("recovered clock not raised");
  chk_data_on_fall: assert property (@(posedge aclk) disable iff (!aresetn)
    ($changed(raw_rx_data_out) || $changed(decoded_rx_data_out)) |-> $fell(recovered_clk_out))
    else $error("data off fall");
endmodule
`default_nettype wire

// ---- line_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
// far-side line transmitter: rails and line clock; the clock stands still between frames
module line_partner (
  output logic pos_o,
  output logic neg_o,
  output logic clk_o
);
  // idle: clock low, rails low
  initial begin
    pos_o = 1'b0;
    neg_o = 1'b0;
    clk_o = 1'b0;
  end
  // one frame, lsb first; rz sends 100 ns pulses every 300 ns, else 200 ns clocked bits
  task automatic send(input logic [3:0] p, input logic [3:0] n, input int cnt, input logic fall, input logic rz);
    #3;
    for (int i = 0; i < cnt; i++) begin
      // nrz rise: data settles half a period before the rising edge
      if (rz || !fall) {pos_o, neg_o} = {p[i], n[i]};
      #100 clk_o = !rz;
      // nrz fall: data moves on the rising edge, sampled on the falling one
      if (rz) {pos_o, neg_o} = 2'b00;
      else if (fall) {pos_o, neg_o} = {p[i], n[i]};
      #100 clk_o = 1'b0;
      if (rz) #100;
    end
    #100;
    // in nrz, released rails show the inverse of the last level; rz leaves them low
    if (!rz) {pos_o, neg_o} = ~{pos_o, neg_o};
  endtask
endmodule
`default_nettype wire

// ---- tb_rx_input.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rx_input_consts.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin $display("[FAIL] %s exp %h got %h", nm, e, g); n_mismatch++; end end
module tb_rx_input
  import rx_input_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic [31:0] awa = '0, wd = '0, ara = '0, rdata;
  logic awr, wr, bv, arr, rv, spos, sneg, oep, oen, rclk, dec, raw, bvld, bdat, bcv, ppos, pneg, pclk;
  logic bit_ready = 1'b1, apos = 1'b0, aneg = 1'b0, rclk_q = 1'b0, rclk_qq = 1'b0, raw_q = 1'b0;
  logic [1:0] bresp, rresp;
  logic [1:0] q[$];
  logic [1:0] rq[$]; // decoded and raw outputs at each recovered clock fall
  logic [3:0] exp_d; // expected data of a clocked-mode frame
  logic [4:0] modes[4] = '{5'h00, 5'h04, 5'h01, 5'h05};
  int n_mismatch = 0, total_checks = 0, n_rise = 0, bad_edge = 0, dec_hi = 0;
  // shared rail wires: device drives them while sliced outputs are enabled
  wire logic rail_p = oep ? spos : ppos;
  wire logic rail_n = oen ? sneg : pneg;
  initial forever #12.5 aclk = ~aclk;
  line_partner u_line_partner (.pos_o(ppos), .neg_o(pneg), .clk_o(pclk));
  rx_input u_rx_input (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
    .rx_pos_rail_in(rail_p), .rx_neg_rail_in(rail_n), .sliced_pos_pulse_out(spos), .sliced_neg_pulse_out(sneg),
    .sliced_pos_oe(oep), .sliced_neg_oe(oen), .ext_line_clk_in(pclk), .analog_pos_in(apos),
    .analog_neg_in(aneg), .recovered_clk_out(rclk), .decoded_rx_data_out(dec), .raw_rx_data_out(raw),
    .bit_valid(bvld), .bit_ready(bit_ready), .bit_data(bdat), .bit_cv(bcv));
  // stream capture and output timing watch
  always @(posedge aclk) begin
    if (bvld === 1'b1 && bit_ready === 1'b1) q.push_back({bdat, bcv});
    rclk_q <= rclk;
    rclk_qq <= rclk_q;
    raw_q <= raw;
    if (rclk === 1'b1 && rclk_q === 1'b0) n_rise++;
    if (rclk === 1'b0 && rclk_q === 1'b1) rq.push_back({dec, raw});
    if (dec === 1'b1) dec_hi++;
    // raw data may move only with a fall of the recovered clock
    if (aresetn && raw !== raw_q && !(rclk_q && !rclk) && !(rclk_qq && !rclk_q)) bad_edge++;
  end
  task automatic report_and_stop();
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // axi4-lite write, address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge aclk);
    awa <= {24'h0, a};
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
      if (bv === 1'b1) break;
    end
    brdy <= 1'b0;
    if (i == 40) begin n_mismatch++; report_and_stop(); end
    `CHK("bresp", er, bresp)
  endtask
  // axi4-lite read, masked data compare
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
    int i;
    @(posedge aclk);
    ara <= {24'h0, a};
    arv <= 1'b1;
    rrdy <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arr === 1'b1) arv <= 1'b0;
      if (rv === 1'b1) break;
    end
    rrdy <= 1'b0;
    if (i == 40) begin n_mismatch++; report_and_stop(); end
    `CHK("rresp", er, rresp)
    `CHK("rdata", e, rdata & m)
  endtask
  // set mode, send one frame, let the bits drain
  task automatic frame(input logic [4:0] c, input logic [3:0] p, input logic [3:0] n, input int cnt);
    axw(`ADDR_CTRL, {27'h0, c}, `RESP_OKAY);
    repeat (4) @(posedge aclk);
    q.delete();
    rq.delete();
    n_rise = 0;
    dec_hi = 0;
    u_line_partner.send(p, n, cnt, c[`CTRL_FALL], c[`CTRL_RZ]);
    repeat (20) @(posedge aclk);
  endtask
  // compare captured bits in order; ones picks out marks only
  task automatic check_q(input logic [3:0] ed, input logic [3:0] ec, input int cnt, input logic ones);
    int k;
    k = 0;
    foreach (q[j]) if (!ones || q[j][1]) begin
      if (k < cnt) `CHK("bit", {ed[k], ec[k]}, q[j])
      k++;
    end
    `CHK("bit count", cnt, k)
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`ADDR_CTRL, {27'h0, `CTRL_RST}, 32'hffffffff, `RESP_OKAY);
    axr(8'h40, 32'h0, 32'hffffffff, `RESP_SLVERR);
    axw(8'h40, 32'h0, `RESP_SLVERR);
    axw(`ADDR_STAT, 32'h0, `RESP_SLVERR);
    // rz marks +,-,+,+ : the last repeats polarity
    frame(5'h02, 4'b1101, 4'b0010, 4);
    check_q(4'hf, 4'b1000, 4, 1'b1);
    `CHK("rz clock", 1'b1, n_rise > 0)
    // clocked modes: dual rise, dual fall, single rise, single fall
    foreach (modes[m]) begin
      exp_d = modes[m][0] ? 4'b1010 : 4'b1100;
      frame(modes[m], 4'b1010, 4'b0110, 4);
      check_q(exp_d, modes[m][0] ? 4'b0110 : 4'b0010, 4, 1'b0);
      `CHK("line clock", 1'b1, n_rise > 0)
      // rising-edge modes: every bit leaves on a recovered clock fall inside the frame
      if (!modes[m][`CTRL_FALL]) begin
        `CHK("serial count", 4, rq.size())
        foreach (rq[j]) if (j < 4) `CHK("serial out", {2{exp_d[j]}}, rq[j])
      end
    end
    // raw select keeps the decoded output low
    frame(5'h10, 4'b1010, 4'b0000, 4);
    `CHK("decoded low", 0, dec_hi)
    `CHK("raw on fall", 0, bad_edge)
    // receiver stalls: two words kept, the third refused
    bit_ready <= 1'b0;
    frame(5'h00, 4'b0011, 4'b0000, 3);
    axr(`ADDR_STAT, 32'h1, 32'h1, `RESP_OKAY);
    bit_ready <= 1'b1;
    repeat (8) @(posedge aclk);
    check_q(4'b0011, 4'b0000, 2, 1'b0);
    // analog slicer on: rails become sliced outputs
    frame(5'h08, 4'b0000, 4'b0000, 0);
    `CHK("pos oe", 1'b1, oep)
    `CHK("neg oe", 1'b1, oen)
    apos <= 1'b1;
    repeat (6) @(posedge aclk);
    `CHK("sliced pos", 2'b10, {spos, sneg})
    apos <= 1'b0;
    aneg <= 1'b1;
    repeat (6) @(posedge aclk);
    `CHK("sliced neg", 2'b01, {spos, sneg})
    aneg <= 1'b0;
    repeat (20) @(posedge aclk);
    `CHK("analog clock", 1'b1, n_rise > 0)
    axw(`ADDR_CTRL, 32'h0, `RESP_OKAY);
    `CHK("oe off", 2'b00, {oep, oen})
    report_and_stop();
  end
endmodule
`default_nettype wire
